// ---- shared/eeprom_ctl_pkg.sv ----
// constants and types for the eeprom program/erase control block
// What this block does
// - 256-byte array at window 0x0400..0x04ff, read like rom, byte programmable.
// - erased byte reads 0xff; programmed bits read zero.
// - oscillator select bit picks rc timing; reset clears it; read/write.
// - two-bit erase mode: none, byte, block, whole array (skipped when latched address bits 1:0 are zero); reset clears.
// - block erase clears the whole 128-byte half holding the latched address.
// - latch enable low forces erase mode and power enable to zero.
// - latch enable set and power off: array write captures address and data.
// - power enable only sets when latch enable already set; always readable.
// - power enable applies charge pump; clearing removes it; software times pulse.
// - any reset clears latch enable and power enable.
// - reset copies stored protect bit into working protect latch, stored bits untouched.
// - protect bit zero blocks erase/program of upper block; lower never protected.
// - protect erased to one keeps upper block protected until next reset.
// - protect bit programmed to zero only while latch enable set.
// - array reads while latch enable set return all ones.
// - program: latch, write, power, clear latch; accesses read all ones meanwhile.
// - another byte programs only after latch enable cleared and set again.
package eeprom_ctl_pkg;
    localparam int ARRAY_BYTES = 256;
    localparam logic [15:0] ARRAY_BASE = 16'h0400;
    localparam logic [15:0] ARRAY_LAST = 16'h04ff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // axi byte addresses of the control window
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] OPTS_OFFSET = 12'h004;
    localparam logic [11:0] ARRAY_OFFSET = 12'h400;
    localparam logic [11:0] ARRAY_END = 12'h7fc;
    // control, options and address bit positions
    localparam int POWER_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam int MODE_LO_BIT = 2;
    localparam int MODE_HI_BIT = 3;
    localparam int OSC_BIT = 7;
    localparam int PROTECT_BIT = 0;
    localparam int UPPER_BIT = 7;
    localparam logic [7:0] OPTS_ERASED = 8'hff;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        ERASE_NONE = 2'b00,
        ERASE_BYTE = 2'b01,
        ERASE_BLOCK = 2'b10,
        ERASE_ALL = 2'b11
    } erase_mode_t;
    typedef struct packed {
        logic rc_osc_select;
        logic [2:0] spare;
        erase_mode_t erase_mode;
        logic latch_enable;
        logic program_power_enable;
    } ctrl_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } capture_t;
endpackage

// ---- src/eeprom_program_erase_control.sv ----
// eeprom program/erase sequencer with axi4-lite register and array window
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eeprom_program_erase_control (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [11:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [11:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic charge_pump_on_out,
    output logic rc_clock_select_out
);
    eeprom_ctl_pkg::ctrl_t ctrl_r;
    eeprom_ctl_pkg::capture_t cap_r;
    logic cap_valid_r;
    logic armed_r;
    logic [7:0] mem_r [0:eeprom_ctl_pkg::ARRAY_BYTES-1];
    // erased state of a fresh part; deliberately outside every reset
    logic [7:0] opts_store_r = eeprom_ctl_pkg::OPTS_ERASED;
    logic protect_latch_r;
    logic opts_loaded_r;
    logic power_q_r;
    logic opts_cap_r;
    logic [11:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // all checks share this clock and reset
    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    // write channel capture; address and data may come in either order
    wire aw_take = s_axi_awvalid_in && !aw_held_r && !bvalid_r;
    wire w_take = s_axi_wvalid_in && !w_held_r && !bvalid_r;
    wire [11:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr_in;
    wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata_in;
    wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb_in;
    wire wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take);
    wire wr_lane0 = ws[0];
    wire wr_ctrl = wr_fire && (wa == eeprom_ctl_pkg::CTRL_OFFSET);
    wire wr_opts = wr_fire && (wa == eeprom_ctl_pkg::OPTS_OFFSET);
    wire wr_in_array = (wa >= eeprom_ctl_pkg::ARRAY_OFFSET) && (wa <= eeprom_ctl_pkg::ARRAY_END);
    wire wr_array = wr_fire && wr_in_array;
    wire wr_ok = (wa == eeprom_ctl_pkg::CTRL_OFFSET) || (wa == eeprom_ctl_pkg::OPTS_OFFSET)
                 || wr_in_array;
    wire [7:0] wr_index = wa[9:2];
    wire [7:0] wbyte = wd[7:0];

    // control register next value
    wire new_latch = wbyte[eeprom_ctl_pkg::LATCH_BIT];
    // power only sets on top of an already-set latch
    wire new_power = wbyte[eeprom_ctl_pkg::POWER_BIT] && ctrl_r.latch_enable && new_latch;
    eeprom_ctl_pkg::ctrl_t ctrl_nxt;
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl && wr_lane0) begin
            ctrl_nxt.rc_osc_select = wbyte[eeprom_ctl_pkg::OSC_BIT];
            ctrl_nxt.latch_enable = new_latch;
            ctrl_nxt.program_power_enable = new_power;
            ctrl_nxt.erase_mode = eeprom_ctl_pkg::erase_mode_t'(
                wbyte[eeprom_ctl_pkg::MODE_HI_BIT:eeprom_ctl_pkg::MODE_LO_BIT]);
        end
        ctrl_nxt.spare = 3'h0;
        if (!ctrl_nxt.latch_enable) begin
            ctrl_nxt.erase_mode = eeprom_ctl_pkg::ERASE_NONE;
            ctrl_nxt.program_power_enable = 1'b0;
        end
    end

    // capture only while latched with power off
    wire capture_now = wr_array && wr_lane0 && ctrl_r.latch_enable
                       && !ctrl_r.program_power_enable && armed_r;
    wire latch_fall = ctrl_r.latch_enable && !ctrl_nxt.latch_enable;
    wire power_rise = ctrl_r.program_power_enable && !power_q_r;

    // target protection uses the working latch only
    wire upper_target = cap_r.addr[eeprom_ctl_pkg::UPPER_BIT];
    wire blocked = upper_target && !protect_latch_r;
    wire do_op = power_rise && cap_valid_r;
    // cell views for the checks; the twin sits at the same offset in the other half
    wire [7:0] cell_now = mem_r[cap_r.addr];
    wire [7:0] twin_index = {!upper_target, cap_r.addr[eeprom_ctl_pkg::UPPER_BIT-1:0]};
    wire [7:0] cell_twin = mem_r[twin_index];
    wire [7:0] prog_expect = cell_now & cap_r.data;
    wire stored_protect = opts_store_r[eeprom_ctl_pkg::PROTECT_BIT];
    wire prog_mode = (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_NONE);
    wire block_mode = (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_BLOCK);
    wire bulk_skip = (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_ALL)
                     && (cap_r.addr[1:0] == 2'b00);

    genvar gi;
    generate
        for (gi = 0; gi < eeprom_ctl_pkg::ARRAY_BYTES; gi++) begin : g_cell
            localparam logic [7:0] IDX = 8'(gi);
            wire upper_cell = IDX[eeprom_ctl_pkg::UPPER_BIT];
            wire cell_prot = upper_cell && !protect_latch_r;
            wire hit_byte = (cap_r.addr == IDX);
            wire hit_block = (upper_cell == upper_target);
            wire bulk_ok = (cap_r.addr[1:0] != 2'b00);
            wire erase_hit =
                (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_BYTE && hit_byte) ||
                (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_BLOCK && hit_block) ||
                (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_ALL && bulk_ok);
            wire prog_hit = (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_NONE) && hit_byte;
            always_ff @(posedge clk_sys_in) begin
                if (do_op && !cell_prot && erase_hit) begin
                    mem_r[gi] <= eeprom_ctl_pkg::ERASED_BYTE;
                end else if (do_op && !cell_prot && prog_hit) begin
                    mem_r[gi] <= mem_r[gi] & cap_r.data;
                end
            end
        end
    endgenerate

    // options store lives in the array technology; reset leaves it alone
    wire opt_pgm = wr_opts && wr_lane0 && ctrl_r.latch_enable;
    always_ff @(posedge clk_sys_in) begin
        if (opt_pgm) begin
            opts_store_r <= wbyte;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            opts_cap_r <= 1'b0;
        end else begin
            opts_cap_r <= 1'b1;
        end
    end

    // working latch reloads once after each reset release
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            protect_latch_r <= 1'b0;
            opts_loaded_r <= 1'b0;
        end else if (!opts_loaded_r) begin
            protect_latch_r <= opts_store_r[eeprom_ctl_pkg::PROTECT_BIT];
            opts_loaded_r <= 1'b1;
        end else if (opt_pgm && !wbyte[eeprom_ctl_pkg::PROTECT_BIT]) begin
            protect_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_r <= '0;
            power_q_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            power_q_r <= ctrl_r.program_power_enable;
        end
    end

    // one operation per latch session; re-arm on latch clear
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cap_r <= '0;
            cap_valid_r <= 1'b0;
            armed_r <= 1'b1;
        end else if (latch_fall || !ctrl_r.latch_enable) begin
            cap_valid_r <= 1'b0;
            armed_r <= 1'b1;
        end else if (capture_now) begin
            cap_r.addr <= wr_index;
            cap_r.data <= wbyte;
            cap_valid_r <= 1'b1;
        end else if (do_op) begin
            cap_valid_r <= 1'b0;
            armed_r <= 1'b0;
        end
    end

    // axi write side
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= eeprom_ctl_pkg::AXI_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? eeprom_ctl_pkg::AXI_OKAY : eeprom_ctl_pkg::AXI_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr_in;
                end
                if (w_take) begin
                    w_held_r <= 1'b1;
                    wdata_r <= s_axi_wdata_in;
                    wstrb_r <= s_axi_wstrb_in;
                end
                if (bvalid_r && s_axi_bready_in) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    // axi read side
    wire ar_take = s_axi_arvalid_in && !rvalid_r;
    wire [11:0] ra = s_axi_araddr_in;
    wire rd_in_array = (ra >= eeprom_ctl_pkg::ARRAY_OFFSET) && (ra <= eeprom_ctl_pkg::ARRAY_END);
    wire [7:0] rd_index = ra[9:2];
    // raw cell behind the read, for the read check
    wire [7:0] rd_cell = mem_r[rd_index];
    // latched or powered array hides contents
    wire [7:0] array_byte = ctrl_r.latch_enable ? eeprom_ctl_pkg::ERASED_BYTE
                                                : mem_r[rd_index];
    wire rd_ctrl = (ra == eeprom_ctl_pkg::CTRL_OFFSET);
    wire rd_opts = (ra == eeprom_ctl_pkg::OPTS_OFFSET);
    wire rd_ok = rd_ctrl || rd_opts || rd_in_array;
    wire [7:0] rd_byte = rd_ctrl ? ctrl_r : rd_opts ? opts_store_r
                         : rd_in_array ? array_byte : 8'h00;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= eeprom_ctl_pkg::AXI_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= rd_ok ? eeprom_ctl_pkg::AXI_OKAY : eeprom_ctl_pkg::AXI_SLVERR;
        end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready_out = !aw_held_r && !bvalid_r;
    assign s_axi_wready_out = !w_held_r && !bvalid_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_arready_out = !rvalid_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;
    assign charge_pump_on_out = ctrl_r.program_power_enable;
    assign rc_clock_select_out = ctrl_r.rc_osc_select;

    a_latch_forces_zero: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        !ctrl_r.latch_enable |-> (ctrl_r.erase_mode == eeprom_ctl_pkg::ERASE_NONE)
        && !ctrl_r.program_power_enable) else $error("mode or power set without latch");
    a_power_needs_latch: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(ctrl_r.program_power_enable) |-> $past(ctrl_r.latch_enable))
        else $error("power set without prior latch");
    a_no_capture_powered: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        ctrl_r.program_power_enable |=> $stable(cap_r)) else $error("capture while powered");
    a_latch_reads_ones: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        ar_take && rd_in_array && ctrl_r.latch_enable |=> rdata_r[7:0] == 8'hff)
        else $error("latched read not all ones");
    a_pump_follows_bit: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        charge_pump_on_out == ctrl_r.program_power_enable) else $error("pump mismatch");
    a_protect_upper_cell: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        do_op && blocked |=> $stable(mem_r[cap_r.addr])) else $error("protected byte changed");
    a_one_per_session: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        do_op |=> !cap_valid_r && (!armed_r || !ctrl_r.latch_enable))
        else $error("second op without latch cycle");
    a_opts_need_latch: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        !ctrl_r.latch_enable && opts_cap_r |=> $stable(opts_store_r))
        else $error("options changed without latch");
    a_no_idle_capture: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        !ctrl_r.latch_enable |=> !cap_valid_r) else $error("capture without latch");

    // single- and multi-cycle shapes for the checks below
    sequence s_prog_pulse;
        do_op && !blocked && prog_mode;
    endsequence
    sequence s_erase_pulse;
        do_op && !blocked && !prog_mode && !bulk_skip;
    endsequence
    sequence s_latch_opens;
        !ctrl_r.latch_enable ##1 ctrl_r.latch_enable;
    endsequence
    sequence s_spent_session;
        do_op ##1 ctrl_r.latch_enable;
    endsequence
    sequence s_write_stalls;
        s_axi_bvalid_out && !s_axi_bready_in;
    endsequence
    sequence s_read_stalls;
        s_axi_rvalid_out && !s_axi_rready_in;
    endsequence

    // array operations land on the right cells
    a_program_lands: assert property (
        s_prog_pulse |=> cell_now == $past(prog_expect))
        else $error("bad program");
    a_erase_to_ones: assert property (
        s_erase_pulse |=> cell_now == eeprom_ctl_pkg::ERASED_BYTE)
        else $error("bad erase");
    a_block_spares_twin: assert property (
        do_op && block_mode |=> $stable(cell_twin))
        else $error("other half changed");

    // control register sessions
    a_open_without_power: assert property (
        s_latch_opens |-> !ctrl_r.program_power_enable)
        else $error("power with opening latch");
    a_spent_disarmed: assert property (
        s_spent_session |-> !armed_r && !cap_valid_r)
        else $error("session still armed");
    a_capture_when_open: assert property (
        $rose(cap_valid_r) |-> $past(ctrl_r.latch_enable)
        && !$past(ctrl_r.program_power_enable)) else $error("bad capture");
    a_pump_off_unlatched: assert property (
        !ctrl_r.latch_enable |-> !charge_pump_on_out)
        else $error("pump without latch");

    // options latch and reset
    a_reload_protect: assert property (
        $rose(opts_loaded_r) |-> protect_latch_r == $past(stored_protect))
        else $error("bad protect reload");
    a_protect_only_falls: assert property (
        opts_loaded_r |=> !$rose(protect_latch_r))
        else $error("protect rose");
    a_release_clears: assert property (
        $rose(reset_n_in) |-> ctrl_r == '0)
        else $error("control not cleared");
    a_store_survives: assert property (
        $rose(reset_n_in) |-> $stable(opts_store_r))
        else $error("options store reset");

    // bus answers
    a_read_shows_cell: assert property (
        ar_take && rd_in_array && !ctrl_r.latch_enable |=> rdata_r[7:0] == $past(rd_cell))
        else $error("bad array read");
    a_read_answers: assert property (
        ar_take |=> s_axi_rvalid_out)
        else $error("no read answer");
    a_write_answers: assert property (
        wr_fire |=> s_axi_bvalid_out)
        else $error("no write answer");
    a_unmapped_write: assert property (
        wr_fire && !wr_ok |=> s_axi_bresp_out == eeprom_ctl_pkg::AXI_SLVERR)
        else $error("unmapped write not refused");
    a_bresp_holds: assert property (
        s_write_stalls |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write answer dropped");
    a_rdata_holds: assert property (
        s_read_stalls |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read answer dropped");
endmodule
`default_nettype wire

// ---- tb/cpu_bus_model.sv ----
// axi4-lite master standing in for the cpu core
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input wire logic clk_in,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [11:0] awaddr_out,
    output logic wvalid_out,
    input wire logic wready_in,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    input wire logic bvalid_in,
    output logic bready_out,
    input wire logic [1:0] bresp_in,
    output logic arvalid_out,
    input wire logic arready_in,
    output logic [11:0] araddr_out,
    input wire logic rvalid_in,
    output logic rready_out,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in
);
    initial begin
        {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
        {awaddr_out, araddr_out, wdata_out, wstrb_out} = '0;
    end
    // handshakes judged at the falling edge; nothing moves before the next rise
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, aw, dw, bv;
        {aw, dw, bv} = 3'b110;
        @(posedge clk_in);
        {awvalid_out, wvalid_out, bready_out} <= 3'b111;
        awaddr_out <= a;
        wdata_out <= {24'h000000, d};
        wstrb_out <= 4'h1;
        while (aw || dw || !bv) begin
            @(negedge clk_in);
            ta = awvalid_out && awready_in;
            tw = wvalid_out && wready_in;
            {bv, r} = {bvalid_in, bresp_in};
            @(posedge clk_in);
            // released payload turned over so a stale value cannot pass
            if (ta) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
                aw = 1'b0;
            end
            if (tw) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~wdata_out;
                dw = 1'b0;
            end
        end
        bready_out <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, rv;
        rv = 1'b0;
        @(posedge clk_in);
        {arvalid_out, rready_out} <= 2'b11;
        araddr_out <= a;
        while (!rv) begin
            @(negedge clk_in);
            ta = arvalid_out && arready_in;
            {rv, d, r} = {rvalid_in, rdata_in, rresp_in};
            @(posedge clk_in);
            if (ta) begin
                arvalid_out <= 1'b0;
                araddr_out <= ~a;
            end
        end
        rready_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the eeprom program/erase control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [11:0] ctl_a = eeprom_ctl_pkg::CTRL_OFFSET;
    localparam logic [11:0] opt_a = eeprom_ctl_pkg::OPTS_OFFSET;
    localparam int rc_settle_cycles = 8;
    logic clk_sys_in, reset_n_in, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, pump, rc_sel;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0] ws;
    logic [1:0] bres, rres;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    eeprom_program_erase_control u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
        .s_axi_bresp_out(bres), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .s_axi_rdata_out(rdat), .s_axi_rresp_out(rres), .charge_pump_on_out(pump),
        .rc_clock_select_out(rc_sel));
    cpu_bus_model u_cpu (.clk_in(clk_sys_in), .awvalid_out(awv), .awready_in(awr),
        .awaddr_out(awa), .wvalid_out(wv), .wready_in(wrdy), .wdata_out(wd), .wstrb_out(ws),
        .bvalid_in(bv), .bready_out(br), .bresp_in(bres), .arvalid_out(arv),
        .arready_in(arr), .araddr_out(ara), .rvalid_in(rv), .rready_out(rr),
        .rdata_in(rdat), .rresp_in(rres));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic finish_test;
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] ea(input logic [7:0] i);
        return {2'b01, i, 2'b00};
    endfunction
    task automatic w(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        u_cpu.wr(a, d, r);
        chk({30'h0, r}, {30'h0, eeprom_ctl_pkg::AXI_OKAY});
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        u_cpu.rd(a, d, r);
        chk(d, {24'h000000, e});
        chk({30'h0, r}, {30'h0, eeprom_ctl_pkg::AXI_OKAY});
    endtask
    task automatic prog(input logic [7:0] i, input logic [7:0] d);
        w(ctl_a, 8'h02);
        w(ea(i), d);
        w(ctl_a, 8'h03);
        w(ctl_a, 8'h00);
    endtask
    task automatic erase(input logic [1:0] m, input logic [7:0] i);
        w(ctl_a, {4'h0, m, 2'b10});
        w(ea(i), 8'h00);
        w(ctl_a, {4'h0, m, 2'b11});
        w(ctl_a, 8'h00);
    endtask
    // first request only at the fourth edge after release
    task automatic sreset;
        @(posedge clk_sys_in);
        reset_n_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rchk(ctl_a, 8'h00);
        rchk(opt_a, 8'hff);
        w(ctl_a, 8'h03);
        rchk(ctl_a, 8'h02);
        chk({31'h0, pump}, 32'h0);
        w(ctl_a, 8'h0e);
        rchk(ctl_a, 8'h0e);
        w(ctl_a, 8'h0c);
        rchk(ctl_a, 8'h00);
        w(ctl_a, 8'h80);
        rchk(ctl_a, 8'h80);
        chk({31'h0, rc_sel}, 32'h1);
        w(ctl_a, 8'h00);
        u_cpu.rd(12'h100, d, r);
        chk({30'h0, r}, {30'h0, eeprom_ctl_pkg::AXI_SLVERR});
        u_cpu.wr(12'h104, 8'h02, r);
        chk({30'h0, r}, {30'h0, eeprom_ctl_pkg::AXI_SLVERR});
        rchk(ctl_a, 8'h00);
    endtask
    task automatic t_bulk;
        w(ctl_a, 8'h0e);
        w(ea(8'h01), 8'h00);
        w(ctl_a, 8'h0f);
        chk({31'h0, pump}, 32'h1);
        rchk(ctl_a, 8'h0f);
        rchk(ea(8'h01), 8'hff);
        w(ctl_a, 8'h00);
        chk({31'h0, pump}, 32'h0);
        for (int i = 0; i < 256; i++) rchk(ea(8'(i)), 8'hff);
    endtask
    task automatic t_prog;
        prog(8'h05, 8'h5a);
        rchk(ea(8'h05), 8'h5a);
        w(ctl_a, 8'h02);
        w(ea(8'h06), 8'h11);
        w(ctl_a, 8'h03);
        rchk(ea(8'h06), 8'hff);
        w(ctl_a, 8'h02);
        w(ea(8'h07), 8'h22);
        w(ctl_a, 8'h03);
        w(ctl_a, 8'h00);
        rchk(ea(8'h06), 8'h11);
        rchk(ea(8'h07), 8'hff);
        w(ea(8'h08), 8'h00);
        rchk(ea(8'h08), 8'hff);
    endtask
    task automatic t_erase;
        prog(8'h10, 8'h44);
        prog(8'h90, 8'h33);
        erase(2'b01, 8'h05);
        rchk(ea(8'h05), 8'hff);
        rchk(ea(8'h06), 8'h11);
        erase(2'b10, 8'h85);
        rchk(ea(8'h90), 8'hff);
        rchk(ea(8'h10), 8'h44);
    endtask
    task automatic t_prot;
        w(opt_a, 8'hfe);
        rchk(opt_a, 8'hff);
        prog(8'ha0, 8'h0f);
        rchk(ea(8'ha0), 8'h0f);
        w(ctl_a, 8'h02);
        w(opt_a, 8'hfe);
        w(ctl_a, 8'h00);
        rchk(opt_a, 8'hfe);
        erase(2'b01, 8'ha0);
        rchk(ea(8'ha0), 8'h0f);
        erase(2'b10, 8'h12);
        rchk(ea(8'h10), 8'hff);
        w(ctl_a, 8'h82);
        repeat (rc_settle_cycles) @(posedge clk_sys_in);
        w(ea(8'hff), 8'hff);
        w(ctl_a, 8'h83);
        chk({31'h0, pump}, 32'h1);
        sreset();
        chk({31'h0, pump}, 32'h0);
        chk({31'h0, rc_sel}, 32'h0);
        rchk(ctl_a, 8'h00);
        rchk(opt_a, 8'hfe);
        erase(2'b01, 8'ha0);
        rchk(ea(8'ha0), 8'h0f);
        w(ctl_a, 8'h02);
        w(opt_a, 8'hff);
        w(ctl_a, 8'h00);
        erase(2'b01, 8'ha0);
        rchk(ea(8'ha0), 8'h0f);
        sreset();
        rchk(opt_a, 8'hff);
        erase(2'b01, 8'ha0);
        rchk(ea(8'ha0), 8'hff);
    endtask
    initial begin
        reset_n_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_regs();
        t_bulk();
        t_prog();
        t_erase();
        t_prot();
        finish_test();
    end
endmodule
`default_nettype wire
